// >>> core/fdma_pkg.sv
// constants for the four-channel dma register block
`default_nettype none
package fdma_pkg;
    // host port offsets
    localparam logic [7:0] REG_CHAN_LAST = 8'h07;
    localparam logic [7:0] REG_MASK = 8'h0a;
    localparam logic [7:0] REG_MODE = 8'h0b;
    localparam logic [7:0] REG_FF_CLR = 8'h0c;
    localparam logic [7:0] REG_PAGE_CH1 = 8'h83;
    localparam logic [7:0] REG_PAGE_CH2 = 8'h81;
    localparam logic [7:0] REG_PAGE_CH3 = 8'h82;
    // mode byte: bits 7:2 are stored per channel, bits 1:0 pick it
    localparam int MODE_STORE_LSB = 2;
    localparam int ST_TYPE_LSB = 0;
    localparam int ST_AUTO = 2;
    localparam int ST_DIR = 3;
    localparam int ST_SVC_LSB = 4;
    localparam int MASK_SET_BIT = 2;
    localparam int PAGE_BITS = 4;
    // service and transfer codes
    localparam logic [1:0] SVC_DEMAND = 2'h0;
    localparam logic [1:0] SVC_SINGLE = 2'h1;
    localparam logic [1:0] SVC_BLOCK = 2'h2;
    localparam logic [1:0] TYPE_VERIFY = 2'h0;
    localparam logic [1:0] TYPE_WRITE = 2'h1;
    localparam logic [1:0] TYPE_READ = 2'h2;
    // reset values and counts
    localparam logic [3:0] MASK_RESET = 4'hf;
    localparam logic [5:0] MODE_RESET = 6'h00;
    localparam logic [15:0] WORD_RESET = 16'h0000;
    localparam logic [7:0] PAGE_RESET = 8'h00;
    localparam logic [15:0] LEN_LAST = 16'h0001;
    localparam logic [15:0] ONE = 16'h0001;
endpackage : fdma_pkg
`default_nettype wire

// >>> core/fdma_regs.sv
// four-channel byte dma: register port, channel engine and fifo
`default_nettype none

module fdma_fifo #(
    parameter int WIDTH = 8,
    parameter int DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // fill side
    input wire logic [WIDTH-1:0] inData,
    input wire logic inValid,
    output logic inReady,
    // drain side
    output logic [WIDTH-1:0] outData,
    output logic outValid,
    input wire logic outReady
);
    localparam int AW = $clog2(DEPTH);
    localparam int CW = AW + 1;
    localparam logic [CW-1:0] FULL = CW'(DEPTH);

    logic [WIDTH-1:0] mem [DEPTH];
    logic [AW-1:0] wrPtr;
    logic [AW-1:0] rdPtr;
    logic [CW-1:0] count;

    wire push = inValid & inReady;
    wire pop = outValid & outReady;
    wire [CW-1:0] next_count = count + CW'(push) - CW'(pop);

    assign outValid = count != '0;
    assign outData = mem[rdPtr];

    always_ff @(posedge clk)
    begin
        if (push)
            mem[wrPtr] <= inData;
    end

    // ready is registered so the card sees a flop
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            wrPtr <= '0;
            rdPtr <= '0;
            count <= '0;
            inReady <= 1'b1;
        end
        else
        begin
            wrPtr <= wrPtr + AW'(push);
            rdPtr <= rdPtr + AW'(pop);
            count <= next_count;
            inReady <= next_count != FULL;
        end
    end
endmodule : fdma_fifo

module fdma_regs #(
    parameter int FIFO_DEPTH = 4
) (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // host i/o port
    input wire logic [7:0] ioAddr,
    input wire logic ioWrite,
    input wire logic ioRead,
    input wire logic [7:0] ioWrData,
    output logic [7:0] ioRdData,
    // card request pins
    input wire logic [3:0] dmaReqPin,
    output logic [3:0] dmaAck,
    // card byte streams
    input wire logic [7:0] perInData,
    input wire logic perInValid,
    output logic perInReady,
    output logic [7:0] perOutData,
    output logic perOutValid,
    // system memory
    output logic [19:0] memAddr,
    output logic memWrite,
    output logic [7:0] memWrData,
    output logic memRead,
    input wire logic [7:0] memRdData,
    input wire logic memRdValid
);
    typedef enum logic [1:0] {ST_IDLE, ST_XFER, ST_WAIT} fdma_state_t;

    logic [3:0] reqMeta;
    logic [3:0] reqSync;
    logic bytePtr;
    logic [15:0] baseAddr [4];
    logic [15:0] curAddr [4];
    logic [15:0] baseLen [4];
    logic [15:0] curLen [4];
    logic [5:0] mode [4];
    logic [7:0] page [4];
    logic [3:0] mask;
    logic [3:0] tcFlag;
    fdma_state_t state;
    logic [1:0] act;

    default clocking cb @(posedge clk); endclocking
    default disable iff (sys_rst);

    // host decode
    wire chanHit = ioAddr <= fdma_pkg::REG_CHAN_LAST;
    wire chanWr = ioWrite & chanHit;
    wire chanAcc = (ioWrite | ioRead) & chanHit;
    wire [1:0] regCh = ioAddr[2:1];
    wire regIsLen = ioAddr[0];
    wire modeWr = ioWrite & (ioAddr == fdma_pkg::REG_MODE);
    wire maskWr = ioWrite & (ioAddr == fdma_pkg::REG_MASK);
    wire ffClr = ioWrite & (ioAddr == fdma_pkg::REG_FF_CLR);
    wire statusRd = ioRead & (ioAddr == fdma_pkg::REG_MODE);
    wire [1:0] wrCh = ioWrData[1:0];
    wire [3:0] pageHit = {ioAddr == fdma_pkg::REG_PAGE_CH3,
                          ioAddr == fdma_pkg::REG_PAGE_CH2,
                          ioAddr == fdma_pkg::REG_PAGE_CH1, 1'b0};
    wire [1:0] pageIdx = pageHit[1] ? 2'h1 : pageHit[2] ? 2'h2 : 2'h3;

    // read data selection
    wire [15:0] chanVal = regIsLen ? curLen[regCh] : curAddr[regCh];
    wire [7:0] chanByte = bytePtr ? chanVal[15:8] : chanVal[7:0];
    wire [7:0] statusByte = {reqSync, tcFlag};
    wire [7:0] rdMux = chanHit ? chanByte
                     : (ioAddr == fdma_pkg::REG_MODE) ? statusByte
                     : (|pageHit) ? page[pageIdx] : 8'h00;

    // active channel fields
    wire [5:0] actMode = mode[act];
    wire [1:0] actType = actMode[fdma_pkg::ST_TYPE_LSB +: 2];
    wire [1:0] actSvc = actMode[fdma_pkg::ST_SVC_LSB +: 2];
    wire actDir = actMode[fdma_pkg::ST_DIR];
    wire actAuto = actMode[fdma_pkg::ST_AUTO];
    wire actFinal = curLen[act] == fdma_pkg::LEN_LAST;
    wire actLive = ~mask[act];
    wire isWrite = actType == fdma_pkg::TYPE_WRITE;
    wire isRead = actType == fdma_pkg::TYPE_READ;
    wire [19:0] physAddr = {page[act][fdma_pkg::PAGE_BITS-1:0], curAddr[act]};

    // engine decisions
    wire fifoValid;
    wire [7:0] fifoData;
    wire inXfer = (state == ST_XFER) & actLive;
    wire fifoTake = inXfer & isWrite;
    wire doStep = (inXfer & ((isWrite & fifoValid) | (~isWrite & ~isRead)))
                | ((state == ST_WAIT) & memRdValid);
    wire keepGoing = ~actFinal & ((actSvc == fdma_pkg::SVC_BLOCK)
                   | ((actSvc == fdma_pkg::SVC_DEMAND) & reqSync[act]));
    wire [3:0] eligible = reqSync & ~mask;
    wire [1:0] pickCh = eligible[0] ? 2'h0 : eligible[1] ? 2'h1
                      : eligible[2] ? 2'h2 : 2'h3;

    // card bytes bound for memory, one byte per transfer
    fdma_fifo #(
        .WIDTH(8),
        .DEPTH(FIFO_DEPTH)
    ) u_fifo (
        .clk(clk),
        .sys_rst(sys_rst),
        .inData(perInData),
        .inValid(perInValid),
        .inReady(perInReady),
        .outData(fifoData),
        .outValid(fifoValid),
        .outReady(fifoTake)
    );

    // request pins cross in through two flops
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            reqMeta <= 4'h0;
            reqSync <= 4'h0;
        end
        else
        begin
            reqMeta <= dmaReqPin;
            reqSync <= reqMeta;
        end
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            bytePtr <= 1'b0;
        else if (ffClr)
            bytePtr <= 1'b0;
        else if (chanAcc)
            bytePtr <= ~bytePtr;
    end

    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
            ioRdData <= 8'h00;
        else if (ioRead)
            ioRdData <= rdMux;
    end

    for (genvar c = 0; c < 4; c++)
    begin : g_ch
        wire hostHit = chanWr & (regCh == 2'(c));
        wire stepHit = doStep & (act == 2'(c));
        wire restore = stepHit & actFinal & actAuto;
        wire selHit = wrCh == 2'(c);

        // host writes hit both start and current copies
        always_ff @(posedge clk or posedge sys_rst)
        begin
            if (sys_rst)
            begin
                baseAddr[c] <= fdma_pkg::WORD_RESET;
                curAddr[c] <= fdma_pkg::WORD_RESET;
            end
            else if (hostHit & ~regIsLen)
            begin
                if (bytePtr)
                begin
                    baseAddr[c][15:8] <= ioWrData;
                    curAddr[c][15:8] <= ioWrData;
                end
                else
                begin
                    baseAddr[c][7:0] <= ioWrData;
                    curAddr[c][7:0] <= ioWrData;
                end
            end
            else if (restore)
                curAddr[c] <= baseAddr[c];
            else if (stepHit)
                curAddr[c] <= actDir ? curAddr[c] - fdma_pkg::ONE
                                     : curAddr[c] + fdma_pkg::ONE;
        end

        always_ff @(posedge clk or posedge sys_rst)
        begin
            if (sys_rst)
            begin
                baseLen[c] <= fdma_pkg::WORD_RESET;
                curLen[c] <= fdma_pkg::WORD_RESET;
            end
            else if (hostHit & regIsLen)
            begin
                if (bytePtr)
                begin
                    baseLen[c][15:8] <= ioWrData;
                    curLen[c][15:8] <= ioWrData;
                end
                else
                begin
                    baseLen[c][7:0] <= ioWrData;
                    curLen[c][7:0] <= ioWrData;
                end
            end
            else if (restore)
                curLen[c] <= baseLen[c];
            else if (stepHit)
                curLen[c] <= curLen[c] - fdma_pkg::ONE;
        end

        always_ff @(posedge clk or posedge sys_rst)
        begin
            if (sys_rst)
            begin
                mode[c] <= fdma_pkg::MODE_RESET;
                page[c] <= fdma_pkg::PAGE_RESET;
            end
            else
            begin
                if (modeWr & selHit)
                    mode[c] <= ioWrData[7:fdma_pkg::MODE_STORE_LSB];
                if (ioWrite & pageHit[c])
                    page[c] <= ioWrData;
            end
        end

        // a finished block without reload masks itself
        always_ff @(posedge clk or posedge sys_rst)
        begin
            if (sys_rst)
                mask[c] <= fdma_pkg::MASK_RESET[c];
            else if (stepHit & actFinal & ~actAuto)
                mask[c] <= 1'b1;
            else if (maskWr & selHit)
                mask[c] <= ioWrData[fdma_pkg::MASK_SET_BIT];
        end

        // set beats the clear done by a status read
        always_ff @(posedge clk or posedge sys_rst)
        begin
            if (sys_rst)
                tcFlag[c] <= 1'b0;
            else if (stepHit & actFinal)
                tcFlag[c] <= 1'b1;
            else if (statusRd)
                tcFlag[c] <= 1'b0;
        end
    end

    // channel engine
    always_ff @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            state <= ST_IDLE;
            act <= 2'h0;
            dmaAck <= 4'h0;
            memAddr <= 20'h00000;
            memWrite <= 1'b0;
            memWrData <= 8'h00;
            memRead <= 1'b0;
            perOutData <= 8'h00;
            perOutValid <= 1'b0;
        end
        else
        begin
            memWrite <= 1'b0;
            memRead <= 1'b0;
            perOutValid <= 1'b0;
            case (state)
                ST_IDLE:
                begin
                    if (|eligible)
                    begin
                        act <= pickCh;
                        dmaAck <= 4'h1 << pickCh;
                        state <= ST_XFER;
                    end
                end
                ST_XFER:
                begin
                    if (!actLive)
                    begin
                        dmaAck <= 4'h0;
                        state <= ST_IDLE;
                    end
                    else if (isRead)
                    begin
                        memRead <= 1'b1;
                        memAddr <= physAddr;
                        state <= ST_WAIT;
                    end
                    else if (doStep)
                    begin
                        memWrite <= isWrite;
                        memAddr <= physAddr;
                        memWrData <= fifoData;
                        dmaAck <= keepGoing ? dmaAck : 4'h0;
                        state <= keepGoing ? ST_XFER : ST_IDLE;
                    end
                end
                ST_WAIT:
                begin
                    if (memRdValid)
                    begin
                        perOutData <= memRdData;
                        perOutValid <= 1'b1;
                        dmaAck <= keepGoing ? dmaAck : 4'h0;
                        state <= keepGoing ? ST_XFER : ST_IDLE;
                    end
                end
                default:
                    state <= ST_IDLE;
            endcase
        end
    end

    sequence s_final;
        doStep && actFinal;
    endsequence

    sequence s_lowAfterClear;
        ffClr ##1 !chanAcc ##1 (chanWr && !regIsLen);
    endsequence

    property p_ffclr;
        ffClr |=> !bytePtr;
    endproperty
    a_ffclr: assert property (p_ffclr) else $error("byte pointer not cleared");

    property p_toggle;
        chanAcc |=> bytePtr != $past(bytePtr);
    endproperty
    a_toggle: assert property (p_toggle) else $error("byte pointer did not flip");

    property p_lowfirst;
        s_lowAfterClear |=> baseAddr[$past(regCh)][7:0] == $past(ioWrData);
    endproperty
    a_lowfirst: assert property (p_lowfirst) else $error("first byte not low");

    property p_mode;
        modeWr |=> mode[$past(wrCh)] == $past(ioWrData[7:2]);
    endproperty
    a_mode: assert property (p_mode) else $error("mode not stored");

    property p_mask;
        maskWr && !doStep |=> mask[$past(wrCh)] == $past(ioWrData[2]);
    endproperty
    a_mask: assert property (p_mask) else $error("mask write lost");

    property p_masked;
        state == ST_XFER && !actLive |=> state == ST_IDLE && dmaAck == 4'h0;
    endproperty
    a_masked: assert property (p_masked) else $error("masked channel served");

    property p_status;
        statusRd |=> ioRdData == {$past(reqSync), $past(tcFlag)};
    endproperty
    a_status: assert property (p_status) else $error("status byte wrong");

    property p_tc;
        s_final |=> tcFlag[$past(act)];
    endproperty
    a_tc: assert property (p_tc) else $error("final count flag missing");

    property p_inc;
        doStep && !actFinal && !actDir && !chanWr
            |=> curAddr[$past(act)] == $past(curAddr[act]) + 16'h0001;
    endproperty
    a_inc: assert property (p_inc) else $error("address did not increment");

    property p_restore;
        (s_final and (actAuto && !chanWr)) |=> curLen[$past(act)] == $past(baseLen[act]);
    endproperty
    a_restore: assert property (p_restore) else $error("length not reloaded");

    property p_page;
        doStep && isWrite |=> memWrite && memAddr == $past(physAddr);
    endproperty
    a_page: assert property (p_page) else $error("memory address wrong");
endmodule : fdma_regs
`default_nettype wire

// >>> dv/fdma_card_model.sv
// behavioural i/o card and system memory on the far side of the dma block
`default_nettype none
module fdma_card_model (
    // clock and reset
    input wire logic clk,
    input wire logic sys_rst,
    // card requests and byte streams
    output logic [3:0] dmaReqPin,
    input wire logic [3:0] dmaAck,
    output logic [7:0] perInData,
    output logic perInValid,
    input wire logic perInReady,
    input wire logic [7:0] perOutData,
    input wire logic perOutValid,
    // memory side
    input wire logic [19:0] memAddr,
    input wire logic memWrite,
    input wire logic [7:0] memWrData,
    input wire logic memRead,
    output logic [7:0] memRdData,
    output logic memRdValid
);
    timeunit 1ns;
    timeprecision 1ps;
    logic [3:0] reqOn = 4'h0;
    logic [3:0] ackLast = 4'h0;
    logic [7:0] nextByte = 8'h50;
    logic [7:0] stored;
    logic [7:0] mem [logic [19:0]];
    logic [19:0] rdAddr = 20'h00000;
    logic [19:0] wAddr [$];
    logic [7:0] wData [$];
    logic [7:0] outQ [$];
    logic [19:0] rAddrQ [$];
    int toSend = 0;
    int rdWait = 0;
    int nRd = 0;
    int nWr = 0;
    int nOut = 0;
    int nStrobe = 0;
    int nAckEnd = 0;
    assign dmaReqPin = reqOn;
    // one byte per handshake; idle data shows the inverse so it never looks valid
    assign perInValid = (toSend > 0);
    assign perInData = perInValid ? nextByte : ~nextByte;
    task automatic start(input int ch, input int n);
        reqOn[ch] = 1'b1;
        toSend = n;
    endtask : start
    task automatic stop(input int ch);
        reqOn[ch] = 1'b0;
    endtask : stop
    always @(posedge clk or posedge sys_rst)
    begin
        if (sys_rst)
        begin
            memRdValid <= 1'b0;
            memRdData <= 8'h00;
            rdWait <= 0;
        end
        else
        begin
            if (perInValid && perInReady)
            begin
                toSend <= toSend - 1;
                nextByte <= nextByte + 8'h01;
            end
            if (memWrite)
            begin
                mem[memAddr] = memWrData;
                wAddr.push_back(memAddr);
                wData.push_back(memWrData);
                nWr <= nWr + 1;
            end
            if (perOutValid)
            begin
                outQ.push_back(perOutData);
                nOut <= nOut + 1;
            end
            if ((ackLast & ~dmaAck) != 4'h0)
                nAckEnd <= nAckEnd + 1;
            ackLast <= dmaAck;
            if (memWrite || memRead)
                nStrobe <= nStrobe + 1;
            // answers alternate between prompt and slow
            stored = mem.exists(rdAddr) ? mem[rdAddr] : ~rdAddr[7:0];
            memRdValid <= (rdWait == 1);
            memRdData <= (rdWait == 1) ? stored : ~memRdData;
            if (memRead)
            begin
                rdAddr <= memAddr;
                rAddrQ.push_back(memAddr);
                rdWait <= 1 + 3 * (nRd % 2);
                nRd <= nRd + 1;
            end
            else if (rdWait > 0)
                rdWait <= rdWait - 1;
        end
    end
endmodule : fdma_card_model
`default_nettype wire

// >>> dv/tb_fdma_regs.sv
// self-checking bench for the four-channel dma register block
`default_nettype none
`define CHK(g, e) begin samples_checked++; if ((g) !== (e)) begin n_errors++; \
    $display("BAD t=%0t got=%h exp=%h", $time, (g), (e)); end end
module tb_fdma_regs;
    timeunit 1ns;
    timeprecision 1ps;
    localparam logic [19:0] PHYS3 = 20'h51234;
    logic clk = 1'b0;
    logic sys_rst = 1'b1;
    logic [7:0] ioAddr = 8'h00;
    logic ioWrite = 1'b0;
    logic ioRead = 1'b0;
    logic [7:0] ioWrData = 8'h00;
    logic [7:0] ioRdData, perInData, perOutData, memWrData, memRdData;
    logic [3:0] dmaReqPin, dmaAck;
    logic perInValid, perInReady, perOutValid, memWrite, memRead, memRdValid;
    logic [19:0] memAddr;
    int n_errors = 0;
    int samples_checked = 0;
    int cycles = 0;
    int strobes;
    int acks;
    always #12.5 clk = ~clk;
    fdma_regs #(.FIFO_DEPTH(4)) dut (.clk(clk), .sys_rst(sys_rst), .ioAddr(ioAddr),
        .ioWrite(ioWrite), .ioRead(ioRead), .ioWrData(ioWrData), .ioRdData(ioRdData),
        .dmaReqPin(dmaReqPin), .dmaAck(dmaAck), .perInData(perInData),
        .perInValid(perInValid), .perInReady(perInReady), .perOutData(perOutData),
        .perOutValid(perOutValid), .memAddr(memAddr), .memWrite(memWrite),
        .memWrData(memWrData), .memRead(memRead), .memRdData(memRdData),
        .memRdValid(memRdValid));
    fdma_card_model card (.clk(clk), .sys_rst(sys_rst), .dmaReqPin(dmaReqPin),
        .dmaAck(dmaAck), .perInData(perInData), .perInValid(perInValid),
        .perInReady(perInReady), .perOutData(perOutData), .perOutValid(perOutValid),
        .memAddr(memAddr), .memWrite(memWrite), .memWrData(memWrData),
        .memRead(memRead), .memRdData(memRdData), .memRdValid(memRdValid));
    task automatic complete_run();
        $display("comparisons=%0d mismatches=%0d", samples_checked, n_errors);
        if (n_errors == 0 && samples_checked > 0)
            $display("All tests passed");
        else
            $display("Some tests failed");
        $finish;
    endtask : complete_run
    task automatic wr(input logic [7:0] a, input logic [7:0] d);
        @(negedge clk);
        ioAddr = a;
        ioWrData = d;
        ioWrite = 1'b1;
        @(negedge clk);
        ioWrite = 1'b0;
    endtask : wr
    task automatic rd(input logic [7:0] a, input logic [7:0] e);
        @(negedge clk);
        ioAddr = a;
        ioRead = 1'b1;
        @(negedge clk);
        ioRead = 1'b0;
        `CHK(ioRdData, e)
    endtask : rd
    // 0 memory writes, 1 bytes to the card, 2 ends of service
    task automatic waitCount(input int which, input int target);
        int got;
        got = 0;
        for (int i = 0; i < 400 && got < target; i++)
        begin
            @(negedge clk);
            got = (which == 0) ? card.nWr : (which == 1) ? card.nOut : card.nAckEnd;
        end
        `CHK(got, target)
    endtask : waitCount
    always @(posedge clk)
    begin
        cycles++;
        if (cycles == 5000)
        begin
            n_errors++;
            complete_run();
        end
    end
    initial
    begin
        repeat (5) @(negedge clk);
        sys_rst = 1'b0;
        rd(8'h0b, 8'h00);
        `CHK({dmaAck, perInReady, memWrite, memRead, perOutValid}, 8'h08)
        wr(8'h08, 8'hff);
        rd(8'h08, 8'h00);
        $display("test reset done");
        wr(8'h0c, 8'h00);
        wr(8'h00, 8'h11);
        wr(8'h0c, 8'h5a);
        wr(8'h00, 8'h77);
        wr(8'h00, 8'h66);
        wr(8'h01, 8'hcd);
        wr(8'h01, 8'hab);
        rd(8'h00, 8'h77);
        rd(8'h00, 8'h66);
        rd(8'h01, 8'hcd);
        rd(8'h01, 8'hab);
        $display("test pointer done");
        card.start(3, 2);
        wr(8'h0a, 8'h07);
        wr(8'h0c, 8'h00);
        wr(8'h0b, 8'h47);
        wr(8'h82, {4'h0, PHYS3[19:16]});
        wr(8'h06, PHYS3[7:0]);
        wr(8'h06, PHYS3[15:8]);
        wr(8'h07, 8'h02);
        wr(8'h07, 8'h00);
        rd(8'h0b, 8'h80);
        `CHK(dmaAck, 4'h0)
        wr(8'h0a, 8'h03);
        waitCount(0, 2);
        `CHK(card.wAddr[0], PHYS3)
        `CHK(card.wData[0], 8'h50)
        `CHK(card.wAddr[1], PHYS3 + 20'h00001)
        `CHK(card.wData[1], 8'h51)
        rd(8'h0b, 8'h88);
        card.stop(3);
        repeat (4) @(negedge clk);
        rd(8'h0b, 8'h00);
        $display("test write done");
        card.start(1, 0);
        wr(8'h0a, 8'h05);
        wr(8'h0c, 8'h00);
        wr(8'h83, 8'h0a);
        wr(8'h02, 8'h01);
        wr(8'h02, 8'h00);
        wr(8'h03, 8'h02);
        wr(8'h03, 8'h00);
        wr(8'h0b, 8'h29);
        wr(8'h0a, 8'h01);
        waitCount(1, 2);
        `CHK(card.rAddrQ[0], 20'ha0001)
        `CHK(card.rAddrQ[1], 20'ha0000)
        `CHK(card.outQ[0], 8'hfe)
        `CHK(card.outQ[1], 8'hff)
        rd(8'h0b, 8'h22);
        card.stop(1);
        wr(8'h0c, 8'h00);
        rd(8'h02, 8'hff);
        rd(8'h02, 8'hff);
        rd(8'h83, 8'h0a);
        $display("test read done");
        card.start(2, 2);
        wr(8'h0a, 8'h06);
        wr(8'h0c, 8'h00);
        wr(8'h81, 8'h03);
        wr(8'h04, 8'h10);
        wr(8'h04, 8'h00);
        wr(8'h05, 8'h02);
        wr(8'h05, 8'h00);
        wr(8'h0b, 8'h96);
        wr(8'h0a, 8'h02);
        waitCount(0, 4);
        `CHK(card.wAddr[2], 20'h30010)
        `CHK(card.wAddr[3], 20'h30011)
        rd(8'h0b, 8'h44);
        wr(8'h0a, 8'h06);
        card.stop(2);
        wr(8'h0c, 8'h00);
        rd(8'h04, 8'h10);
        rd(8'h04, 8'h00);
        $display("test reload done");
        wr(8'h0a, 8'h04);
        wr(8'h0c, 8'h00);
        wr(8'h01, 8'h01);
        wr(8'h01, 8'h00);
        wr(8'h0b, 8'h00);
        card.start(0, 0);
        strobes = card.nStrobe;
        acks = card.nAckEnd;
        wr(8'h0a, 8'h00);
        waitCount(2, acks + 1);
        rd(8'h0b, 8'h11);
        `CHK(card.nStrobe, strobes)
        card.stop(0);
        $display("test verify done");
        complete_run();
    end
endmodule : tb_fdma_regs
`default_nettype wire
